// [common/fifo_cfg_pkg.sv]
/*
 * package for the receive fifo chain configuration block: register
 * offsets, field positions, table sizes and the shared carrier types.
 * assumes a 16-bit register port with byte offsets as printed.
 */
package fifo_cfg_pkg;

    // register byte offsets
    localparam logic [11:0] rx_start_sel_off  = 12'h900;
    localparam logic [11:0] rx_start_data_off = 12'h904;
    localparam logic [11:0] rx_link_sel_off   = 12'h910;
    localparam logic [11:0] rx_link_data_off  = 12'h914;
    localparam logic [11:0] rx_wm_sel_off     = 12'h920;
    localparam logic [11:0] rx_wm_data_off    = 12'h924;
    localparam logic [11:0] tx_start_sel_off  = 12'h980;

    // select register field positions
    localparam int rnw_bit  = 14;
    localparam int busy_bit = 15;

    // field widths and table sizes
    localparam int chan_w  = 8;
    localparam int blk_w   = 10;
    localparam int n_chan  = 256;
    localparam int n_blk   = 1024;

    // reset values
    localparam logic [15:0] sel_reset = 16'h0000;
    localparam logic [9:0]  ptr_reset = 10'h000;
    localparam logic [9:0]  wm_reset  = 10'h001;

    // table access takes one cycle after the select write
    localparam int access_cycles = 1;

    typedef enum logic [1:0] {
        tbl_start,
        tbl_link,
        tbl_wm,
        tbl_tx
    } table_t;

    // one indirect access in flight
    typedef struct packed {
        logic          active;
        table_t        which;
        logic          rnw;
        logic [9:0]    index;
    } access_t;

    // engine-side block progress report
    typedef struct packed {
        logic          valid;
        logic [7:0]    chan;
        logic [9:0]    blk;
        logic          eof;
    } blk_evt_t;

endpackage

// [verif/fifo_cfg_checker.sv]
/* port checker for rx_fifo_chain_config.
   assumes a single clock domain; bound onto the design below. */
`timescale 1ns/1ps
module fifo_cfg_checker (
    input wire logic                   mclk,    // clock
    input wire logic                   reset_n, // async reset
    input wire logic [11:0]            addr,    // offset
    input wire logic [15:0]            wdata,   // write data
    input wire logic                   wr,      // write strobe
    input wire logic                   rd,      // read strobe
    input wire fifo_cfg_pkg::blk_evt_t blk_evt, // engine report
    input wire logic [15:0]            rdata,   // read data
    input wire logic                   dma_req, // dma pulse
    input wire logic [7:0]             dma_chan // dma channel
);
    localparam logic [11:0] ssel = fifo_cfg_pkg::rx_start_sel_off;
    localparam logic [11:0] lsel = fifo_cfg_pkg::rx_link_sel_off;
    localparam logic [11:0] wsel = fifo_cfg_pkg::rx_wm_sel_off;
    localparam logic [11:0] tsel = fifo_cfg_pkg::tx_start_sel_off;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // read data only stands in the cycle after a read strobe
    property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_cause;
        dma_req |-> $past(blk_evt.valid) && dma_chan == $past(blk_evt.chan);
    endproperty
    a_cause: assert property (p_cause) else $error("stray dma");
    property p_eof; blk_evt.valid && blk_evt.eof |=> dma_req; endproperty
    a_eof: assert property (p_eof) else $error("eof no dma");
    // busy must show one cycle after the select write, gone one later
    property p_lbusy;
        wr && addr == lsel ##1 rd && addr == lsel |=> rdata[15];
    endproperty
    a_lbusy: assert property (p_lbusy) else $error("link busy");
    property p_sbusy;
        wr && addr == ssel ##1 rd && addr == ssel |=> rdata[15];
    endproperty
    a_sbusy: assert property (p_sbusy) else $error("start busy");
    property p_wdone;
        wr && addr == wsel ##1 !wr ##1 rd && addr == wsel |=> !rdata[15];
    endproperty
    a_wdone: assert property (p_wdone) else $error("wm busy");
    property p_cmd0;
        rd && (addr == ssel || addr == lsel || addr == wsel) |=> !rdata[14];
    endproperty
    a_cmd0: assert property (p_cmd0) else $error("cmd bit");
    property p_tx;
        wr && addr == tsel ##1 rd && addr == tsel
            |=> rdata[15] && rdata[7:0] == $past(wdata[7:0], 2);
    endproperty
    a_tx: assert property (p_tx) else $error("tx select");
endmodule

bind rx_fifo_chain_config fifo_cfg_checker fifo_cfg_checker_inst (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .blk_evt(blk_evt), .rdata(rdata), .dma_req(dma_req),
    .dma_chan(dma_chan));

// [verif/tb.sv]
/* tb: self-checking bench for rx_fifo_chain_config.
   drives register port and engine reports itself; one 10 MHz clock. */
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] ssel = fifo_cfg_pkg::rx_start_sel_off;
    localparam logic [11:0] sdat = fifo_cfg_pkg::rx_start_data_off;
    localparam logic [11:0] lsel = fifo_cfg_pkg::rx_link_sel_off;
    localparam logic [11:0] ldat = fifo_cfg_pkg::rx_link_data_off;
    localparam logic [11:0] wsel = fifo_cfg_pkg::rx_wm_sel_off;
    localparam logic [11:0] wdat = fifo_cfg_pkg::rx_wm_data_off;
    localparam logic [11:0] tsel = fifo_cfg_pkg::tx_start_sel_off;
    logic                   mclk, reset_n, wr, rd, dma_req, due;
    logic [11:0]            addr;
    logic [15:0]            wdata, rdata, d;
    fifo_cfg_pkg::blk_evt_t blk_evt;
    logic [7:0]             dma_chan, ch;
    logic [9:0]             b [4];
    logic [9:0]             wm, cur;
    int                     err_count, cmp_count, fill;
    int                     seed = 32'h07603b60;

    rx_fifo_chain_config rx_fifo_chain_config_inst (.mclk(mclk),
        .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .blk_evt(blk_evt), .rdata(rdata), .dma_req(dma_req),
        .dma_chan(dma_chan));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    // strobes drop right after their edge; #1 keeps a repeat off that step
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // select write, then poll twice: busy holds one cycle, then drops
    task automatic ind(input logic [11:0] a, input logic c,
                       input logic [9:0] i);
        logic [15:0] e;
        logic [15:0] v;
        e = {1'b1, (a == tsel) & c, 4'h0, i};
        wr_reg(a, {1'b0, c, 4'h0, i});
        rd_reg(a, v);
        chk(v, e);
        rd_reg(a, v);
        chk(v, e & 16'h7fff);
    endtask

    function automatic logic dma_due(int f, logic [9:0] w, logic e);
        return e || (f + 1 >= int'(w));
    endfunction

    task automatic evt(input logic [9:0] k, input logic e);
        due = dma_due(fill, wm, e);
        blk_evt <= '{1'b1, ch, k, e};
        @(posedge mclk);
        blk_evt.valid <= 1'b0;
        #1 chk({15'h0000, dma_req}, {15'h0000, due});
        if (due) chk({8'h00, dma_chan}, {8'h00, ch});
        fill = due ? 0 : fill + 1;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out();
    end

    initial begin
        {reset_n, wr, rd, addr, wdata, err_count, cmp_count} = '0;
        blk_evt = '0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        rd_reg(ssel, d);
        chk(d, fifo_cfg_pkg::sel_reset);
        rd_reg(12'h9f0, d);
        chk(d, 16'h0000);
        // channel ff on the top four blocks first, then random rings
        for (int it = 0; it < 3; it++) begin
            ch = (it == 0) ? 8'hff : 8'($random(seed));
            b[0] = (it == 0) ? 10'h3fc : 10'({$random(seed)} % 1021);
            for (int i = 1; i < 4; i++) b[i] = b[0] + 10'(i);
            wm = 10'(1 + {$random(seed)} % 3);
            for (int i = 0; i < 4; i++) begin
                wr_reg(ldat, {6'h00, b[(i + 1) % 4]});
                ind(lsel, 1'b0, b[i]);
            end
            for (int i = 0; i < 4; i++) begin
                wr_reg(ldat, {6'h00, ~b[(i + 1) % 4]});
                ind(lsel, 1'b1, b[i]);
                rd_reg(ldat, d);
                chk(d, {6'h00, b[(i + 1) % 4]});
            end
            wr_reg(wdat, {6'h00, wm});
            ind(wsel, 1'b0, {2'b00, ch});
            wr_reg(wdat, 16'h0000);
            ind(wsel, 1'b1, {2'b00, ch});
            rd_reg(wdat, d);
            chk(d, {6'h00, wm});
            wr_reg(sdat, {6'h00, b[0]});
            ind(ssel, 1'b0, {2'b00, ch});
            rd_reg(sdat, d);
            chk(d, {6'h00, b[0]});
            // walk the ring; the data register follows the write block
            cur = b[0];
            fill = 0;
            for (int j = 0; j < 5; j++) begin
                evt(cur, 1'b0);
                cur = b[(j + 1) % 4];
                rd_reg(sdat, d);
                chk(d, {6'h00, cur});
            end
            evt(cur, 1'b1);
            ind(tsel, 1'b1, {2'b00, ch});
            ind(tsel, 1'b0, {2'b00, ch});
        end
        close_out();
    end
endmodule

// [verilog/rx_fifo_chain_config.sv]
/*
 * rx_fifo_chain_config: indirect access to the receive start pointer,
 * block link and high watermark tables, plus the transmit start pointer
 * select register. tracks the current write block per channel and raises
 * a dma request when the watermark is reached or a packet ends.
 * assumes a same-clock register port and a same-clock engine report.
 *
 * the register port is a plain strobe port: address, write data, a
 * write strobe and a read strobe, with read data registered one cycle
 * after the read strobe and zero in every other cycle. the port never
 * stalls the host; an indirect access instead shows its progress in the
 * busy bit of its select register.
 *
 * every indirect access completes one cycle after the select write
 * and busy drops on that same edge, so only a poll in the cycle right after the write sees it high.
 * a select write that arrives while its own busy is high is dropped
 * without notice: the host is expected to poll first.
 *
 * the tables have no reset. the host programs links, watermarks and
 * start pointers before it lets the engine report blocks for a channel.
 * the engine report is assumed to come from logic on the same clock and
 * is used without synchronisers.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module rx_fifo_chain_config (
    input  wire logic                    mclk,     // 10 MHz clock
    input  wire logic                    reset_n,  // async reset
    input  wire logic [11:0]             addr,     // register byte offset
    input  wire logic [15:0]             wdata,    // write data
    input  wire logic                    wr,       // write strobe
    input  wire logic                    rd,       // read strobe
    input  wire fifo_cfg_pkg::blk_evt_t  blk_evt,  // engine block report
    output logic      [15:0]             rdata,    // read data, next cycle
    output logic                         dma_req,  // one-cycle dma request
    output logic      [7:0]              dma_chan  // channel to service
);

    // all state of the block except the tables
    // one shared access slot serves every select register; only one
    // indirect access can be in flight, which keeps the table ports
    // single and lets the tables map onto simple ram
    typedef struct packed {
        fifo_cfg_pkg::access_t acc;
        logic [7:0]            start_chan;
        logic [9:0]            start_data;
        logic                  start_busy;
        logic [9:0]            link_blk;
        logic [9:0]            link_data;
        logic                  link_busy;
        logic [7:0]            wm_chan;
        logic [9:0]            wm_data;
        logic                  wm_busy;
        logic [7:0]            tx_chan;
        logic                  tx_rnw;
        logic                  tx_busy;
        logic [15:0]           rdata;
        logic                  dma_req;
        logic [7:0]            dma_chan;
    } state_t;

    state_t state_q;
    state_t state_d;

    // tables: big enough to want real ram, written only by the clocked
    // process so synthesis can map them
    // cur_ptr_q:  block the engine writes next, per channel
    // link_ram_q: next block of every block in the fifo
    // wm_ram_q:   high watermark in blocks, per channel
    // fill_q:     blocks written since the last dma request, per channel
    logic [9:0] cur_ptr_q  [fifo_cfg_pkg::n_chan];
    logic [9:0] link_ram_q [fifo_cfg_pkg::n_blk];
    logic [9:0] wm_ram_q   [fifo_cfg_pkg::n_chan];
    logic [9:0] fill_q     [fifo_cfg_pkg::n_chan];

    // pack a select register for read back
    // the index sits in the low bits, command and busy on top; unused
    // bits read as zero
    function automatic logic [15:0] sel_word(input logic busy,
                                             input logic rnw,
                                             input logic [9:0] idx);
        logic [15:0] w;
        w = {6'h00, idx};
        w[fifo_cfg_pkg::busy_bit] = busy;
        w[fifo_cfg_pkg::rnw_bit]  = rnw;
        return w;
    endfunction

    // table write enables from the access in flight
    // the watermark compare uses the count after this block, so a
    // watermark of one requests dma on every block
    logic acc_go;
    logic acc_wr_start;
    logic acc_wr_link;
    logic acc_wr_wm;
    logic [9:0] fill_next;
    logic       wm_hit;

    always_comb begin
        acc_go       = state_q.acc.active;
        acc_wr_start = acc_go && !state_q.acc.rnw
                       && state_q.acc.which == fifo_cfg_pkg::tbl_start;
        acc_wr_link  = acc_go && !state_q.acc.rnw
                       && state_q.acc.which == fifo_cfg_pkg::tbl_link;
        acc_wr_wm    = acc_go && !state_q.acc.rnw
                       && state_q.acc.which == fifo_cfg_pkg::tbl_wm;
        fill_next    = fill_q[blk_evt.chan] + 10'h001;
        wm_hit       = fill_next >= wm_ram_q[blk_evt.chan];
    end

    // next state: register port, access sequencing, dma request
    // read data and the dma strobe default to zero so each stands for
    // one cycle only; everything else holds unless changed below
    always_comb begin
        state_d = state_q;
        state_d.dma_req = 1'b0;
        state_d.rdata   = 16'h0000;

        // finish the access taken last cycle; busy drops on the edge that writes the table
        // this runs before the write decode, so a new select write in the
        // same cycle can take the slot that is being freed here
        if (state_q.acc.active) begin
            state_d.acc.active = 1'b0;
            case (state_q.acc.which)
                fifo_cfg_pkg::tbl_start: begin
                    state_d.start_busy = 1'b0;
                end
                fifo_cfg_pkg::tbl_link: begin
                    if (state_q.acc.rnw) begin
                        state_d.link_data =
                            link_ram_q[state_q.acc.index];
                    end
                    state_d.link_busy = 1'b0;
                end
                fifo_cfg_pkg::tbl_wm: begin
                    if (state_q.acc.rnw) begin
                        state_d.wm_data =
                            wm_ram_q[state_q.acc.index[7:0]];
                    end
                    state_d.wm_busy = 1'b0;
                end
                default: begin
                    state_d.tx_busy = 1'b0;
                end
            endcase
        end

        // writes; a select write while busy is ignored so the access
        // in flight is never corrupted
        if (wr) begin
            if (addr == fifo_cfg_pkg::rx_start_sel_off) begin
                if (!state_q.start_busy) begin
                    state_d.start_chan = wdata[7:0];
                    state_d.start_busy = 1'b1;
                    state_d.acc = '{1'b1, fifo_cfg_pkg::tbl_start,
                                    wdata[fifo_cfg_pkg::rnw_bit],
                                    {2'b00, wdata[7:0]}};
                end
            end else if (addr == fifo_cfg_pkg::rx_start_data_off) begin
                state_d.start_data = wdata[9:0];
            end else if (addr == fifo_cfg_pkg::rx_link_sel_off) begin
                if (!state_q.link_busy) begin
                    state_d.link_blk  = wdata[9:0];
                    state_d.link_busy = 1'b1;
                    state_d.acc = '{1'b1, fifo_cfg_pkg::tbl_link,
                                    wdata[fifo_cfg_pkg::rnw_bit],
                                    wdata[9:0]};
                end
            end else if (addr == fifo_cfg_pkg::rx_link_data_off) begin
                state_d.link_data = wdata[9:0];
            end else if (addr == fifo_cfg_pkg::rx_wm_sel_off) begin
                if (!state_q.wm_busy) begin
                    state_d.wm_chan = wdata[7:0];
                    state_d.wm_busy = 1'b1;
                    state_d.acc = '{1'b1, fifo_cfg_pkg::tbl_wm,
                                    wdata[fifo_cfg_pkg::rnw_bit],
                                    {2'b00, wdata[7:0]}};
                end
            end else if (addr == fifo_cfg_pkg::rx_wm_data_off) begin
                state_d.wm_data = wdata[9:0];
            end else if (addr == fifo_cfg_pkg::tx_start_sel_off) begin
                if (!state_q.tx_busy) begin
                    state_d.tx_chan = wdata[7:0];
                    state_d.tx_rnw  = wdata[fifo_cfg_pkg::rnw_bit];
                    state_d.tx_busy = 1'b1;
                    state_d.acc = '{1'b1, fifo_cfg_pkg::tbl_tx,
                                    wdata[fifo_cfg_pkg::rnw_bit],
                                    {2'b00, wdata[7:0]}};
                end
            end
        end

        // reads; unmapped offsets return zero
        // the receive command bits read back as zero: they only start an
        // access and are not kept; the transmit select keeps its bit
        // the start data offset shows where the engine writes now, not
        // what the host last wrote there
        if (rd) begin
            if (addr == fifo_cfg_pkg::rx_start_sel_off) begin
                state_d.rdata = sel_word(state_q.start_busy, 1'b0,
                                         {2'b00, state_q.start_chan});
            end else if (addr == fifo_cfg_pkg::rx_start_data_off) begin
                state_d.rdata = {6'h00,
                                 cur_ptr_q[state_q.start_chan]};
            end else if (addr == fifo_cfg_pkg::rx_link_sel_off) begin
                state_d.rdata = sel_word(state_q.link_busy, 1'b0,
                                         state_q.link_blk);
            end else if (addr == fifo_cfg_pkg::rx_link_data_off) begin
                state_d.rdata = {6'h00, state_q.link_data};
            end else if (addr == fifo_cfg_pkg::rx_wm_sel_off) begin
                state_d.rdata = sel_word(state_q.wm_busy, 1'b0,
                                         {2'b00, state_q.wm_chan});
            end else if (addr == fifo_cfg_pkg::rx_wm_data_off) begin
                state_d.rdata = {6'h00, state_q.wm_data};
            end else if (addr == fifo_cfg_pkg::tx_start_sel_off) begin
                state_d.rdata = sel_word(state_q.tx_busy, state_q.tx_rnw,
                                         {2'b00, state_q.tx_chan});
            end
        end

        // dma request at watermark or end of packet
        // a short packet must not sit in the fifo waiting for blocks
        // that may never come, hence the end of packet term
        if (blk_evt.valid && (wm_hit || blk_evt.eof)) begin
            state_d.dma_req  = 1'b1;
            state_d.dma_chan = blk_evt.chan;
        end
    end

    // state register
    // all select fields, busy flags, data registers and outputs clear
    // on reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // table updates; no reset so the arrays can map onto ram
    // a host start write wins over an engine report in the same cycle;
    // the report's pointer and fill updates are lost for that cycle, though its
    // dma request still goes out, which is acceptable because the host only
    // rewrites a start pointer on an idle channel
    // the fill count restarts with the start pointer so the first
    // watermark after setup counts from zero
    always_ff @(posedge mclk) begin
        if (acc_wr_start) begin
            cur_ptr_q[state_q.acc.index[7:0]] <= state_q.start_data;
            fill_q[state_q.acc.index[7:0]]    <= fifo_cfg_pkg::ptr_reset;
        end else if (blk_evt.valid) begin
            // engine moves on: the pointer read back now follows it
            cur_ptr_q[blk_evt.chan] <= link_ram_q[blk_evt.blk];
            fill_q[blk_evt.chan] <= (wm_hit || blk_evt.eof)
                                    ? fifo_cfg_pkg::ptr_reset : fill_next;
        end
        if (acc_wr_link) begin
            link_ram_q[state_q.acc.index] <= state_q.link_data;
        end
        if (acc_wr_wm) begin
            wm_ram_q[state_q.acc.index[7:0]] <= state_q.wm_data;
        end
    end

    // outputs come straight from the state register
    assign rdata    = state_q.rdata;
    assign dma_req  = state_q.dma_req;
    assign dma_chan = state_q.dma_chan;

endmodule
